//--- bench/cces_remote_ser.sv
// Purpose: Far-side serializer events for the status bank.
// Assumes: One event request per go pulse.
// Notes:   A bad echo stands for returned data that differs.
`timescale 1ns/1ns
`default_nettype none
module cces_remote_ser (
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] port,
	input wire logic [2:0] kind,
	output logic [3:0] seq,
	output logic [3:0] crc,
	output logic [3:0] lock,
	output logic [3:0] wdog,
	output logic [3:0] bad
);
	logic [4:0] hit;
	logic [3:0] one;
	assign hit = go ? 5'h01 << kind : 5'h00;
	assign one = 4'h1 << port;
	// Pulses last one cycle so each request is a single event
	always_ff @(posedge clk)
	begin
		seq <= hit[0] ? one : 4'h0;
		crc <= hit[1] ? one : 4'h0;
		lock <= hit[2] ? one : 4'h0;
		wdog <= hit[3] ? one : 4'h0;
		bad <= hit[4] ? one : 4'h0;
	end
endmodule
`default_nettype wire

//--- bench/cces_status_bank_tb.sv
// Purpose: Self-checking bench for the error status bank.
// Assumes: Read answers one cycle after the strobe.
// Notes:   Events go to port 2 with enhanced checking on, then to port 3 with it off.
`timescale 1ns/1ns
`default_nettype none
module cces_status_bank_tb import cces_pkg::*;;
	logic clk = 0, reset_n = 0, rd_en = 0, wr_en = 0, go = 0, rvalid;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] pp = 2'h0;
	logic [2:0] kk = 3'h0;
	logic [3:0] mw = 4'h0, sw = 4'h0, mir = 4'h0;
	logic [3:0] seq, crc, lock, wdog, bad;
	int fail_count = 0, checks_done = 0, cyc = 0;
	logic [2:0] kt [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h4};
	logic [7:0] et [7] = '{8'h30, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
	cces_status_bank #(.NUM_PORTS(4)) i_cces_status_bank (.clk(clk),
		.reset_n(reset_n), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
		.wdata(wdata), .rdata(rdata), .rvalid(rvalid), .fwd_seq_err(seq),
		.fwd_crc_err(crc), .fwd_lock_err(lock), .watchdog_expired(wdog),
		.master_waiting(mw), .slave_waiting(sw),
		.returned_data_mismatch(bad), .rx_port_status_one_seq(mir),
		.enhanced_check_enable());
	cces_remote_ser i_cces_remote_ser (.clk(clk), .go(go), .port(pp),
		.kind(kk), .seq(seq), .crc(crc), .lock(lock), .wdog(wdog),
		.bad(bad));
	initial forever #20 clk = ~clk;
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected reg %h exp %h got %h", a, e, g);
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(a, e, rvalid ? rdata : 8'hXX);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task ev(input logic [1:0] p, input logic [2:0] k);
		@(posedge clk);
		go <= 1'b1;
		pp <= p;
		kk <= k;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// Bounds a hang; the full run needs about 100 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			give_verdict;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h46, 8'h20);
		rd(8'h47, 8'h00);
		rd(8'h48, 8'h00);
		$display("test reset done");
		wr(8'h4C, 8'h24);
		for (int i = 0; i < 7; i++)
		begin
			mw <= (i < 4) ? 4'hF : 4'h0;
			sw <= (i < 4) ? 4'h0 : 4'hF;
			ev(2'h2, kt[i]);
			rd(8'h47, et[i]);
			rd(8'h47, 8'h00);
		end
		ev(2'h2, 3'h4);
		wr(8'h4C, 8'h10);
		rd(8'h47, 8'h00);
		wr(8'h4C, 8'h24);
		rd(8'h47, 8'h01);
		$display("test enhanced done");
		wr(8'h4C, 8'h38);
		wr(8'h46, 8'h00);
		rd(8'h46, 8'h00);
		mir <= 4'h8;
		rd(8'h47, 8'h20);
		rd(8'h47, 8'h20);
		mw <= 4'hF;
		sw <= 4'h0;
		ev(2'h3, 3'h3);
		rd(8'h47, 8'h20);
		mw <= 4'h0;
		sw <= 4'hF;
		ev(2'h3, 3'h3);
		rd(8'h47, 8'h22);
		$display("test mirror done");
		give_verdict;
	end
endmodule
`default_nettype wire

//--- verilog/cces_map.svh
// Purpose: Register offsets, field positions and reset values for the
//          control channel error status bank.
// Assumes: Byte-wide register space, four receive ports.
// Notes:   Definitions only.
`ifndef CCES_MAP_SVH
`define CCES_MAP_SVH
`define CCES_STATUS_ADDR 8'h47
`define CCES_ERR_CTL_ADDR 8'h46
`define CCES_PORT_SEL_ADDR 8'h4C
`define CCES_BIT_SEQ 5
`define CCES_BIT_MERR 4
`define CCES_BIT_MTO 3
`define CCES_BIT_SERR 2
`define CCES_BIT_STO 1
`define CCES_BIT_RESP 0
`define CCES_BIT_ENH 5
`define CCES_RDPORT_HI 5
`define CCES_RDPORT_LO 4
`define CCES_ENH_RESET 1'h1
`define CCES_FLAGS_RESET 6'h00
`endif

//--- verilog/cces_pkg.sv
// Purpose: Types shared by the control channel error status bank.
// Assumes: Nothing beyond the map header.
// Notes:   Flag vector order matches register bits 5..0.
package cces_pkg;
	typedef logic [5:0] cces_flags_t;
	typedef logic [1:0] cces_port_t;
endpackage

//--- verilog/cces_port_flags.sv
// Purpose: Sticky error flags of one receive port.
// Assumes: Events are one-cycle pulses in the clk domain.
// Notes:   Clear-on-read removes only the flags that were returned.
`timescale 1ns/1ns
`default_nettype none
`include "cces_map.svh"
module cces_port_flags
	import cces_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enhanced_check_enable,
	input wire logic seq_mirror,
	input wire cces_flags_t evt,
	input wire logic rd_done,
	input wire cces_flags_t rd_mask,
	output cces_flags_t flags
);
	typedef struct packed
	{
		cces_flags_t sticky;
	} cces_pf_state_t;
	cces_pf_state_t state_ff;
	cces_pf_state_t nxt_state;
	cces_flags_t gated;
	cces_flags_t clr;

	always_comb
	begin
		gated = evt;
		// Only the slave timeout reports without enhanced checking
		if (!enhanced_check_enable)
		begin
			gated = evt & 6'h02;
		end
		clr = rd_done ? rd_mask : 6'h00;
		nxt_state = state_ff;
		// Set wins over clear
		nxt_state.sticky = (state_ff.sticky & ~clr) | gated;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_ff.sticky <= `CCES_FLAGS_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	always_comb
	begin
		flags = state_ff.sticky;
		if (!enhanced_check_enable)
		begin
			flags[`CCES_BIT_SEQ] = seq_mirror;
		end
	end

	a_seq_mirror: assert property (@(posedge clk) disable iff (!reset_n)
		!enhanced_check_enable |-> flags[5] == seq_mirror)
		else $error("sequence flag not mirroring status");
	a_event_latch: assert property (@(posedge clk) disable iff (!reset_n)
		evt[1] |=> state_ff.sticky[1])
		else $error("slave timeout not latched");
	a_clear_read: assert property (@(posedge clk) disable iff (!reset_n)
		rd_done && rd_mask[0] && !evt[0] |=> !state_ff.sticky[0])
		else $error("response flag not cleared on read");
endmodule
`default_nettype wire

//--- verilog/cces_status_bank.sv
// Purpose: Banked control channel error status with clear-on-read flags.
// Assumes: Register access through a byte-wide read/write strobe port.
// Notes:   A read is captured on rd_en; flags clear one cycle after the data returns.
`timescale 1ns/1ns
`default_nettype none
`include "cces_map.svh"
module cces_status_bank
	import cces_pkg::*;
#(
	parameter int NUM_PORTS = 4
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic [NUM_PORTS-1:0] fwd_seq_err,
	input wire logic [NUM_PORTS-1:0] fwd_crc_err,
	input wire logic [NUM_PORTS-1:0] fwd_lock_err,
	input wire logic [NUM_PORTS-1:0] watchdog_expired,
	input wire logic [NUM_PORTS-1:0] master_waiting,
	input wire logic [NUM_PORTS-1:0] slave_waiting,
	input wire logic [NUM_PORTS-1:0] returned_data_mismatch,
	input wire logic [NUM_PORTS-1:0] rx_port_status_one_seq,
	output logic [NUM_PORTS-1:0] enhanced_check_enable
);
	// The read-port field is two bits wide, so the bank is fixed at four
	if (NUM_PORTS != 4)
	begin : g_bad_ports
		$error("NUM_PORTS must be 4 to match the port select field");
	end

	typedef struct packed
	{
		logic [3:0] enh;
		logic [1:0] rd_port;
		logic [3:0] wr_port;
		logic [7:0] rdata;
		logic rvalid;
		logic clr_pend;
		cces_port_t clr_port;
		cces_flags_t clr_mask;
	} cces_state_t;
	cces_state_t state_ff;
	cces_state_t nxt_state;
	cces_flags_t port_flags [4];
	cces_flags_t sel_flags;

	// A clear still in flight must not be reported again by a back-to-back read
	assign sel_flags = port_flags[state_ff.rd_port] & ~((state_ff.clr_pend
		&& state_ff.clr_port == state_ff.rd_port) ? state_ff.clr_mask
		: 6'h00);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.rvalid = 1'b0;
		nxt_state.clr_pend = 1'b0;
		if (wr_en && addr == `CCES_PORT_SEL_ADDR)
		begin
			nxt_state.rd_port = wdata[`CCES_RDPORT_HI:`CCES_RDPORT_LO];
			nxt_state.wr_port = wdata[3:0];
		end
		if (wr_en && addr == `CCES_ERR_CTL_ADDR)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (state_ff.wr_port[i])
				begin
					nxt_state.enh[i] = wdata[`CCES_BIT_ENH];
				end
			end
		end
		if (rd_en)
		begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata = 8'h00;
			case (addr)
				`CCES_STATUS_ADDR:
				begin
					nxt_state.rdata = {2'h0, sel_flags};
					nxt_state.clr_pend = 1'b1;
					nxt_state.clr_port = state_ff.rd_port;
					nxt_state.clr_mask = sel_flags;
					// Mirrored bit is not ours to clear
					if (!state_ff.enh[state_ff.rd_port])
					begin
						nxt_state.clr_mask[`CCES_BIT_SEQ] = 1'b0;
					end
				end
				`CCES_ERR_CTL_ADDR:
				begin
					nxt_state.rdata = {2'h0, state_ff.enh[state_ff.rd_port], 5'h00};
				end
				`CCES_PORT_SEL_ADDR:
				begin
					nxt_state.rdata = {2'h0, state_ff.rd_port, state_ff.wr_port};
				end
				default:
				begin
					nxt_state.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_ff <= '0;
			state_ff.enh <= {4{`CCES_ENH_RESET}};
			state_ff.wr_port <= 4'h1;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign rdata = state_ff.rdata;
	assign rvalid = state_ff.rvalid;
	assign enhanced_check_enable = state_ff.enh;

	for (genvar p = 0; p < 4; p++)
	begin : g_port
		cces_flags_t evt;
		logic link_err;
		assign link_err = fwd_seq_err[p] | fwd_crc_err[p] | fwd_lock_err[p];
		assign evt[`CCES_BIT_SEQ] = fwd_seq_err[p];
		assign evt[`CCES_BIT_MERR] = link_err & master_waiting[p];
		assign evt[`CCES_BIT_MTO] = watchdog_expired[p] & master_waiting[p];
		assign evt[`CCES_BIT_SERR] = link_err & slave_waiting[p];
		assign evt[`CCES_BIT_STO] = watchdog_expired[p] & slave_waiting[p];
		// Mismatch reported by the echo checker relies on the remote echoing
		assign evt[`CCES_BIT_RESP] = returned_data_mismatch[p];
		cces_port_flags u_flags
		(
			.clk(clk),
			.reset_n(reset_n),
			.enhanced_check_enable(state_ff.enh[p]),
			.seq_mirror(rx_port_status_one_seq[p]),
			.evt(evt),
			.rd_done(state_ff.clr_pend && state_ff.clr_port == 2'(p)),
			.rd_mask(state_ff.clr_mask),
			.flags(port_flags[p])
		);
	end

	a_read_bank: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && addr == 8'h47 |=> rdata == {2'h0, $past(sel_flags)})
		else $error("status read returned wrong bank");
	a_enh_reset: assert property (@(posedge clk)
		!reset_n |=> enhanced_check_enable == 4'hF)
		else $error("enhanced check enable not reset to one");
	a_seq_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		fwd_seq_err[2] && state_ff.enh[2] |=> port_flags[2][5])
		else $error("sequence error not held");
	a_master_to: assert property (@(posedge clk) disable iff (!reset_n)
		watchdog_expired[2] && master_waiting[2] && state_ff.enh[2]
		|=> port_flags[2][3])
		else $error("master timeout not latched");
	a_master_err: assert property (@(posedge clk) disable iff (!reset_n)
		fwd_crc_err[2] && master_waiting[2] && state_ff.enh[2]
		|=> port_flags[2][4])
		else $error("master error not latched");
	a_slave_err: assert property (@(posedge clk) disable iff (!reset_n)
		fwd_lock_err[2] && slave_waiting[2] && state_ff.enh[2]
		|=> port_flags[2][2])
		else $error("slave error not latched");
	a_seq_set: assert property (@(posedge clk) disable iff (!reset_n)
		fwd_seq_err[2] && state_ff.enh[2] |=> port_flags[2][5])
		else $error("sequence error not flagged");
	a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && addr == 8'h47 && state_ff.rd_port == 2'h2 && !wr_en
		&& !(watchdog_expired[2] && slave_waiting[2])
		##1 !slave_waiting[2] |=> !port_flags[2][1])
		else $error("slave timeout not cleared by read");
endmodule
`default_nettype wire
